// *** design/selector_xfer_consts.svh ***
// Offsets, field positions, reset values and timing counts of the transfer block
`ifndef SELECTOR_XFER_CONSTS_SVH
`define SELECTOR_XFER_CONSTS_SVH

// Register byte addresses
`define REG_CTRL 8'h00
`define REG_COUNT 8'h04
`define REG_OUT_DATA 8'h08
`define REG_IN_DATA 8'h0C
`define REG_STATUS 8'h10
`define REG_EXIT 8'h14
`define REG_END_STATUS 8'h18

// Control register bits
`define CTRL_ENABLE 0
`define CTRL_CHAIN 1
`define CTRL_INBOUND 2
`define CTRL_HISPEED 3
`define CTRL_PRI_EN 4

// Status register bits
`define ST_SLICE_REQ 0
`define ST_STARVED 1
`define ST_FORCE 2
`define ST_STOP_ARM 3
`define ST_EOT 4
`define ST_OUT_FIRST 5
`define ST_OUT_SECOND 6
`define ST_IN_FIRST 7
`define ST_END_REQ 8

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Reset values
`define COUNT_RESET 16'h0000
`define BYTE_RESET 8'h00

// Timing: bus-out settling before the reply tag
`define CLK_MHZ 25
`define SETTLE_NS 260
`define SETTLE_CYC ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// *** design/selector_xfer_pkg.sv ***
// Types shared by the transfer block and its bench
package selector_xfer_pkg;

	// Outbound tag sequence, Gray coded along idle -> serve; idle -> stop flips both bits
	typedef enum logic [1:0] {
		OUT_IDLE = 2'b00,
		OUT_SERVE = 2'b01,
		OUT_STOP = 2'b11
	} out_phase_t;

	// Tags and bus arriving from the control unit
	typedef struct packed {
		logic srv_in;
		logic stat_in;
		logic data_in;
		logic [7:0] bus_in;
	} link_in_t;

	// Tags and bus driven toward the control unit
	typedef struct packed {
		logic srv_out;
		logic cmd_out;
		logic data_out;
		logic [7:0] bus_out;
	} link_out_t;

endpackage : selector_xfer_pkg

// *** design/selector_xfer.sv ***
// Hardware-controlled byte transfer logic of a selector channel with AXI4-Lite registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "selector_xfer_consts.svh"

module selector_xfer (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Channel link
	input wire selector_xfer_pkg::link_in_t link_in,
	output selector_xfer_pkg::link_out_t link_out,
	// Processor service requests
	output logic byte_req,
	output logic buffer_starved_priority_req,
	output logic timeslice_force_flag
);
	import selector_xfer_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		// Bus slave
		logic aw_got;
		logic w_got;
		logic [7:0] wr_addr;
		logic [31:0] wr_data;
		logic [3:0] wr_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// Control
		logic hw_transfer_enable_flag;
		logic segment_chain_flag;
		logic inbound_direction_flag;
		logic hispeed;
		logic pri_enable;
		logic [15:0] byte_count_reg;
		// Output stages
		logic [7:0] out_stage_first;
		logic [7:0] out_stage_second;
		logic out_first_full_flag;
		logic out_second_full;
		logic [3:0] settle_cnt;
		out_phase_t out_phase;
		// Input stages
		logic [7:0] in_stage_first;
		logic [7:0] in_stage_second;
		logic in_first_full_flag;
		logic in_first_via_data;
		// Tags and requests
		logic reply_tag_flag;
		logic alt_reply_tag_flag;
		logic cmd_out;
		logic stop_tag_arm_flag;
		logic slice_request_flag;
		logic end_req;
		logic end_of_transfer_flag;
		logic [7:0] end_status;
		logic starved;
		logic force_flag;
		logic byte_req;
	} state_t;

	localparam logic [3:0] SETTLE = 4'(`SETTLE_CYC);

	state_t s;
	state_t next_s;
	logic wr_go;
	logic rd_go;
	logic srv_valid;
	logic data_valid;
	logic carry;
	logic count_step;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		next_s = s;
		carry = 1'b0;
		count_step = 1'b0;
		srv_valid = link_in.srv_in & ~link_in.data_in;
		data_valid = link_in.data_in & ~link_in.srv_in;
		wr_go = s.aw_got & s.w_got & ~s.bvalid;
		rd_go = arvalid & s.arready;

		// Collect address and data in either order, one write at a time
		if (awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.wr_addr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wr_data = wdata;
			next_s.wr_strb = wstrb;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end

		// Register writes; link events below win over software clears
		if (wr_go) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `RESP_OKAY;
			case (s.wr_addr)
				`REG_CTRL: begin
					if (s.wr_strb[0]) begin
						next_s.hw_transfer_enable_flag = s.wr_data[`CTRL_ENABLE];
						next_s.segment_chain_flag = s.wr_data[`CTRL_CHAIN];
						next_s.inbound_direction_flag = s.wr_data[`CTRL_INBOUND];
						next_s.hispeed = s.wr_data[`CTRL_HISPEED];
						next_s.pri_enable = s.wr_data[`CTRL_PRI_EN];
					end
				end
				`REG_COUNT: begin
					if (s.wr_strb[0]) begin
						next_s.byte_count_reg[7:0] = s.wr_data[7:0];
					end
					if (s.wr_strb[1]) begin
						next_s.byte_count_reg[15:8] = s.wr_data[15:8];
					end
				end
				`REG_OUT_DATA: begin
					if (s.wr_strb[0]) begin
						next_s.out_stage_first = s.wr_data[7:0];
						next_s.out_first_full_flag = 1'b1;
						next_s.slice_request_flag = 1'b0;
						next_s.starved = 1'b0;
					end
				end
				`REG_STATUS: begin
					// Write one to clear
					if (s.wr_data[`ST_FORCE]) begin
						next_s.force_flag = 1'b0;
					end
					if (s.wr_data[`ST_EOT]) begin
						next_s.end_of_transfer_flag = 1'b0;
					end
					if (s.wr_data[`ST_END_REQ]) begin
						next_s.end_req = 1'b0;
					end
				end
				`REG_EXIT: begin
					// Chaining keeps the transfer running across segments
					if (!s.segment_chain_flag) begin
						next_s.hw_transfer_enable_flag = 1'b0;
					end
				end
				`REG_IN_DATA, `REG_END_STATUS: begin
					next_s.bresp = `RESP_OKAY;
				end
				default: begin
					next_s.bresp = `RESP_SLVERR;
				end
			endcase
		end

		// Register reads; reading the input byte is the processor taking it
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = `RESP_OKAY;
			next_s.rdata = 32'h0000_0000;
			case (araddr)
				`REG_CTRL: begin
					next_s.rdata[`CTRL_ENABLE] = s.hw_transfer_enable_flag;
					next_s.rdata[`CTRL_CHAIN] = s.segment_chain_flag;
					next_s.rdata[`CTRL_INBOUND] = s.inbound_direction_flag;
					next_s.rdata[`CTRL_HISPEED] = s.hispeed;
					next_s.rdata[`CTRL_PRI_EN] = s.pri_enable;
				end
				`REG_COUNT: begin
					next_s.rdata[15:0] = s.byte_count_reg;
				end
				`REG_OUT_DATA: begin
					next_s.rdata[7:0] = s.out_stage_first;
				end
				`REG_IN_DATA: begin
					next_s.rdata[7:0] = s.in_stage_second;
					next_s.slice_request_flag = 1'b0;
					next_s.starved = 1'b0;
				end
				`REG_STATUS: begin
					next_s.rdata[`ST_SLICE_REQ] = s.slice_request_flag;
					next_s.rdata[`ST_STARVED] = s.starved;
					next_s.rdata[`ST_FORCE] = s.force_flag;
					next_s.rdata[`ST_STOP_ARM] = s.stop_tag_arm_flag;
					next_s.rdata[`ST_EOT] = s.end_of_transfer_flag;
					next_s.rdata[`ST_OUT_FIRST] = s.out_first_full_flag;
					next_s.rdata[`ST_OUT_SECOND] = s.out_second_full;
					next_s.rdata[`ST_IN_FIRST] = s.in_first_full_flag;
					next_s.rdata[`ST_END_REQ] = s.end_req;
				end
				`REG_EXIT: begin
					next_s.rdata = 32'h0000_0000;
				end
				`REG_END_STATUS: begin
					next_s.rdata[7:0] = s.end_status;
				end
				default: begin
					next_s.rresp = `RESP_SLVERR;
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// Outbound transfer
		if (!s.inbound_direction_flag) begin
			// Settling delay so bus-out deskews before service-out
			if (!s.out_second_full || s.out_phase != OUT_IDLE) begin
				next_s.settle_cnt = 4'h0;
			end else if (s.settle_cnt != SETTLE) begin
				next_s.settle_cnt = s.settle_cnt + 4'h1;
			end
			// Runs regardless of transfer enable so staged bytes drain
			case (s.out_phase)
				OUT_IDLE: begin
					if (link_in.srv_in && s.stop_tag_arm_flag) begin
						next_s.out_phase = OUT_STOP;
						next_s.cmd_out = 1'b1;
					end else if (link_in.srv_in && s.out_second_full && s.settle_cnt == SETTLE) begin
						next_s.out_phase = OUT_SERVE;
						next_s.reply_tag_flag = 1'b1;
					end
				end
				OUT_SERVE: begin
					if (!link_in.srv_in) begin
						next_s.out_phase = OUT_IDLE;
						next_s.reply_tag_flag = 1'b0;
						next_s.out_second_full = 1'b0;
						count_step = 1'b1;
						if (!next_s.out_first_full_flag) begin
							next_s.starved = 1'b1;
						end
					end
				end
				OUT_STOP: begin
					if (!link_in.srv_in) begin
						next_s.out_phase = OUT_IDLE;
						next_s.cmd_out = 1'b0;
					end
				end
				default: begin
					next_s.out_phase = OUT_IDLE;
					next_s.reply_tag_flag = 1'b0;
					next_s.cmd_out = 1'b0;
				end
			endcase
			// Refill the second stage and, while transfer is enabled, ask for the next byte
			if (next_s.out_first_full_flag && !next_s.out_second_full) begin
				next_s.out_stage_second = next_s.out_stage_first;
				next_s.out_second_full = 1'b1;
				next_s.out_first_full_flag = 1'b0;
				if (s.hw_transfer_enable_flag) begin
					next_s.slice_request_flag = 1'b1;
				end
			end
			// Device end: staged bytes stay unsent and uncounted
			if (link_in.stat_in && !s.stop_tag_arm_flag && s.out_phase == OUT_IDLE
				&& s.out_first_full_flag && s.out_second_full && !s.slice_request_flag) begin
				next_s.end_of_transfer_flag = 1'b1;
				next_s.end_req = 1'b1;
				next_s.end_status = link_in.bus_in;
			end
		////////////////////////////////////////////////////////////////////////
		// Inbound transfer
		end else begin
			if (s.reply_tag_flag && !link_in.srv_in) begin
				next_s.reply_tag_flag = 1'b0;
			end
			if (s.alt_reply_tag_flag && !link_in.data_in) begin
				next_s.alt_reply_tag_flag = 1'b0;
			end
			// Latch only while both out tags are idle
			if (!s.in_first_full_flag && !s.reply_tag_flag && !s.alt_reply_tag_flag) begin
				if (srv_valid) begin
					next_s.in_stage_first = link_in.bus_in;
					next_s.in_first_full_flag = 1'b1;
					next_s.in_first_via_data = 1'b0;
					next_s.reply_tag_flag = 1'b1;
				end else if (s.hispeed && data_valid) begin
					next_s.in_stage_first = link_in.bus_in;
					next_s.in_first_full_flag = 1'b1;
					next_s.in_first_via_data = 1'b1;
				end
			end
			// Processor behind the control unit
			if (s.in_first_full_flag && s.slice_request_flag) begin
				next_s.starved = 1'b1;
			end
			// Advance only once the processor took the previous byte
			if (s.in_first_full_flag && !s.slice_request_flag && s.hw_transfer_enable_flag) begin
				next_s.in_stage_second = s.in_stage_first;
				next_s.in_first_full_flag = 1'b0;
				next_s.slice_request_flag = 1'b1;
				count_step = 1'b1;
				if (s.in_first_via_data) begin
					next_s.alt_reply_tag_flag = 1'b1;
				end
			end
		end

		// Byte count and its carry
		if (count_step) begin
			{carry, next_s.byte_count_reg} = {1'b0, s.byte_count_reg} + 17'h00001;
			if (carry) begin
				if (s.segment_chain_flag) begin
					next_s.inbound_direction_flag = 1'b0;
				end else begin
					next_s.stop_tag_arm_flag = 1'b1;
				end
			end
		end

		// Status-in after a stop ends the transfer
		if (link_in.stat_in && s.stop_tag_arm_flag) begin
			next_s.stop_tag_arm_flag = 1'b0;
			next_s.end_req = 1'b1;
			next_s.end_status = link_in.bus_in;
		end
		if (s.segment_chain_flag) begin
			next_s.stop_tag_arm_flag = 1'b0;
		end

		// Priority override
		if (next_s.starved && s.pri_enable) begin
			next_s.force_flag = 1'b1;
		end

		// Handshake readies and combined request
		next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
		next_s.wready = ~next_s.w_got & ~next_s.bvalid;
		next_s.arready = ~next_s.rvalid;
		next_s.byte_req = next_s.slice_request_flag | next_s.end_req;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.out_phase <= OUT_IDLE;
			s.byte_count_reg <= `COUNT_RESET;
			s.end_status <= `BYTE_RESET;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	// One driver for the whole link struct
	assign link_out = '{srv_out: s.reply_tag_flag, cmd_out: s.cmd_out, data_out: s.alt_reply_tag_flag,
		bus_out: s.out_stage_second};
	assign byte_req = s.byte_req;
	assign buffer_starved_priority_req = s.starved;
	assign timeslice_force_flag = s.force_flag;

endmodule : selector_xfer

// *** tb/selector_xfer_sva.sv ***
// Checker for the tag handshake and request outputs of the transfer block
`timescale 1ns/100ps
module selector_xfer_sva (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link tags and bus
	input wire selector_xfer_pkg::link_in_t link_in,
	input wire selector_xfer_pkg::link_out_t link_out,
	// Processor requests
	input wire logic byte_req,
	input wire logic buffer_starved_priority_req,
	input wire logic timeslice_force_flag,
	// Write response
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready
);
	import selector_xfer_pkg::*;

	// One domain, so clock and reset are given once
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////
	// Stop tag only answers a service-in, never beside the reply tag
	property p_stop_rise;
		$rose(link_out.cmd_out) |-> $past(link_in.srv_in) && !link_out.srv_out;
	endproperty
	a_stop_rise: assert property (p_stop_rise) else $error("stop tag without service-in");
	property p_stop_drop;
		link_out.cmd_out && !link_in.srv_in |=> !link_out.cmd_out;
	endproperty
	a_stop_drop: assert property (p_stop_drop) else $error("stop tag held after service-in fell");
	// Reply tag follows service-in in both directions
	property p_reply_rise;
		$rose(link_out.srv_out) |-> $past(link_in.srv_in);
	endproperty
	a_reply_rise: assert property (p_reply_rise) else $error("reply tag without service-in");
	property p_reply_drop;
		link_out.srv_out && !link_in.srv_in |=> !link_out.srv_out;
	endproperty
	a_reply_drop: assert property (p_reply_drop) else $error("reply tag held after service-in fell");
	property p_alt_drop;
		link_out.data_out && !link_in.data_in |=> !link_out.data_out;
	endproperty
	a_alt_drop: assert property (p_alt_drop) else $error("data-out held after data-in fell");
	// Bus must have settled seven cycles before the reply tag, and hold under it
	property p_settle;
		$rose(link_out.srv_out) |-> $past(link_out.bus_out, 7) == link_out.bus_out;
	endproperty
	a_settle: assert property (p_settle) else $error("bus out not settled before reply");
	property p_bus_hold;
		link_out.srv_out |-> $stable(link_out.bus_out);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus out moved under reply tag");
	// Force flag only follows a starved request
	property p_force;
		$rose(timeslice_force_flag) |-> buffer_starved_priority_req || $past(buffer_starved_priority_req);
	endproperty
	a_force: assert property (p_force) else $error("force flag without starved request");
	property p_bresp_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped early");

	// Main scenarios reached
	c_stop: cover property ($rose(link_out.cmd_out));
	c_alt: cover property ($rose(link_out.data_out));
	c_force: cover property ($rose(timeslice_force_flag));
	c_end: cover property (link_in.stat_in && byte_req);
endmodule : selector_xfer_sva

bind selector_xfer selector_xfer_sva chk_u (.aclk, .aresetn, .link_in, .link_out, .byte_req,
	.buffer_starved_priority_req, .timeslice_force_flag, .bresp, .bvalid, .bready);

// *** tb/selector_cu_model.sv ***
// Behavioural control unit on the far side of the tagged channel
`timescale 1ns/100ps
module selector_cu_model (
	// Clock
	input wire logic aclk,
	// Link
	input wire selector_xfer_pkg::link_out_t link_out,
	output selector_xfer_pkg::link_in_t link_in,
	// Processor request, seen only to pace the ending and the high-speed input reads
	input wire logic byte_req
);
	import selector_xfer_pkg::*;

	// Idle tags; bus shows a pattern, never a held byte
	initial link_in = '{srv_in: 1'b0, stat_in: 1'b0, data_in: 1'b0, bus_in: 8'hC3};
	// Waits that ran out of time; the bench counts any number of them as one mismatch
	int n_late = 0;

	////////////////////////////////////////////////////////////////
	// Values sampled just after an edge are the ones the edge saw
	function automatic logic hit(input int s);
		case (s)
			0: return link_out.srv_out;
			1: return link_out.data_out;
			2: return link_out.srv_out | link_out.cmd_out;
			3: return byte_req;
			default: return !(link_out.srv_out | link_out.cmd_out);
		endcase
	endfunction : hit

	// Bounded wait so a dead channel cannot hang the model
	task automatic await(input int s);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge aclk);
			if (hit(s)) break;
		end
		if (n == 400) n_late++;
	endtask : await

	// Ask for one output byte; gap makes the unit slow
	task automatic take(input int gap, output logic [7:0] b, output logic stop);
		repeat (gap + 1) @(posedge aclk);
		link_in.srv_in <= 1'b1;
		await(2);
		b = link_out.bus_out;
		stop = link_out.cmd_out;
		link_in.srv_in <= 1'b0;
		await(4);
	endtask : take

	// Status-in with status on the inbound bus
	task automatic stat_on(input logic [7:0] b);
		@(posedge aclk);
		link_in.bus_in <= b;
		link_in.stat_in <= 1'b1;
	endtask : stat_on

	task automatic stat_off();
		@(posedge aclk);
		link_in.stat_in <= 1'b0;
		link_in.bus_in <= ~link_in.bus_in;
	endtask : stat_off

	// Overlapped input: even bytes on the service pair, odd on the data pair
	task automatic hs_stream(input logic [31:0] w);
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			link_in.bus_in <= w[8*i +: 8];
			@(posedge aclk);
			if (i % 2 == 0) link_in.srv_in <= 1'b1;
			else link_in.data_in <= 1'b1;
			@(posedge aclk);
			if (i % 2 == 0) link_in.data_in <= 1'b0;
			else link_in.srv_in <= 1'b0;
			await(i % 2);
		end
		@(posedge aclk);
		link_in.data_in <= 1'b0;
		link_in.bus_in <= ~w[31:24];
	endtask : hs_stream
endmodule : selector_cu_model

// *** tb/selector_xfer_tb.sv ***
// Self-checking bench for the selector channel transfer block
`timescale 1ns/100ps
`include "selector_xfer_consts.svh"
module selector_xfer_tb;
	import selector_xfer_pkg::*;

	// Design inputs, settled at time zero
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	// Design outputs
	logic awready, wready, bvalid, arready, rvalid, byte_req, buffer_starved_priority_req, timeslice_force_flag;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	link_in_t link_in;
	link_out_t link_out;
	int n_errors = 0, checks_done = 0;

	always #20 aclk = ~aclk;

	selector_xfer dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link_in, .link_out,
		.byte_req, .buffer_starved_priority_req, .timeslice_force_flag);
	selector_cu_model cu_u (.aclk, .link_out, .link_in, .byte_req);

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = `RESP_OKAY);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				chk("bresp", 32'(resp), 32'(bresp));
				break;
			end
		end
		if (n == 100) chk("bvalid in time", 32'h1, 32'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask = 32'hFFFFFFFF,
		input logic [1:0] resp = `RESP_OKAY);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				chk("rresp", 32'(resp), 32'(rresp));
				chk($sformatf("read %h", a), exp & mask, rdata & mask);
				break;
			end
		end
		if (n == 100) chk("rvalid in time", 32'h1, 32'h0);
	endtask : rd

	task automatic take(input logic [7:0] exp, input logic stop, input int gap = 0);
		logic [7:0] b;
		logic s;
		cu_u.take(gap, b, s);
		chk("stop tag", 32'(stop), 32'(s));
		if (!stop) chk("bus out", 32'(exp), 32'(b));
	endtask : take

	// Stop answered, then status-in ends the transfer; clears sticky bits after
	task automatic end_seq();
		cu_u.stat_on(8'h0C);
		cu_u.await(3);
		chk("end request", 32'h1, 32'(byte_req));
		cu_u.stat_off();
		rd(`REG_STATUS, 32'h100, 32'h108);
		wr(`REG_STATUS, 32'h114);
	endtask : end_seq

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("idle", 32'h0, 32'({link_out, byte_req, buffer_starved_priority_req, timeslice_force_flag}));
		rd(`REG_STATUS, 32'h0);
		rd(8'h1C, 32'h0, 32'h0, `RESP_SLVERR);
		wr(8'h1C, 32'h0, `RESP_SLVERR);
	endtask : t_reset

	// Three bytes, starvation, exit with two bytes still queued, then stop
	task automatic t_proc_end();
		wr(`REG_CTRL, 32'h11);
		wr(`REG_COUNT, 32'hFFFD);
		wr(`REG_OUT_DATA, 32'hA1);
		take(8'hA1, 1'b0);
		repeat (3) @(posedge aclk);
		chk("starved", 32'h1, 32'(buffer_starved_priority_req));
		chk("force", 32'h1, 32'(timeslice_force_flag));
		wr(`REG_OUT_DATA, 32'hA2);
		chk("starved", 32'h0, 32'(buffer_starved_priority_req));
		wr(`REG_OUT_DATA, 32'hA3);
		wr(`REG_EXIT, 32'h1);
		take(8'hA2, 1'b0, 30);
		repeat (3) @(posedge aclk);
		chk("byte req", 32'h0, 32'(byte_req));
		take(8'hA3, 1'b0);
		rd(`REG_COUNT, 32'h0);
		take(8'h00, 1'b1);
		end_seq();
	endtask : t_proc_end

	// Chained segments ignore exit and carry; last segment ends normally
	task automatic t_chain();
		wr(`REG_CTRL, 32'h03);
		wr(`REG_COUNT, 32'hFFFF);
		wr(`REG_OUT_DATA, 32'hC1);
		take(8'hC1, 1'b0);
		wr(`REG_EXIT, 32'h1);
		wr(`REG_COUNT, 32'hFFFF);
		wr(`REG_OUT_DATA, 32'hC2);
		repeat (2) @(posedge aclk);
		chk("byte req", 32'h1, 32'(byte_req));
		take(8'hC2, 1'b0);
		rd(`REG_STATUS, 32'h0, 32'h8);
		wr(`REG_CTRL, 32'h01);
		wr(`REG_COUNT, 32'hFFFF);
		wr(`REG_OUT_DATA, 32'hC3);
		take(8'hC3, 1'b0);
		take(8'h00, 1'b1);
		end_seq();
	endtask : t_chain

	// Overlapped input while the processor lags behind
	task automatic t_hispeed();
		wr(`REG_CTRL, 32'h0D);
		wr(`REG_COUNT, 32'h0);
		rd(`REG_IN_DATA, 32'h0, 32'h0);
		chk("starved", 32'h0, 32'(buffer_starved_priority_req));
		fork
			cu_u.hs_stream(32'h44332211);
			begin
				repeat (40) @(posedge aclk);
				chk("starved", 32'h1, 32'(buffer_starved_priority_req));
				for (int i = 0; i < 4; i++) begin
					cu_u.await(3);
					rd(`REG_IN_DATA, 32'(8'h11 * (i + 1)), 32'hFF);
					// Byte on the data pair moves up as soon as the first is taken
					if (i == 0) begin
						@(posedge aclk);
						chk("data out", 32'h1, 32'(link_out.data_out));
					end
				end
			end
		join
		rd(`REG_COUNT, 32'h4);
	endtask : t_hispeed

	// Status-in held early is ignored until both stages fill
	task automatic t_dev_end();
		wr(`REG_CTRL, 32'h01);
		wr(`REG_COUNT, 32'h10);
		wr(`REG_OUT_DATA, 32'hB1);
		cu_u.stat_on(8'h5A);
		repeat (12) @(posedge aclk);
		rd(`REG_STATUS, 32'h0, 32'h110);
		wr(`REG_OUT_DATA, 32'hB2);
		repeat (3) @(posedge aclk);
		chk("byte req", 32'h1, 32'(byte_req));
		rd(`REG_STATUS, 32'h110, 32'h110);
		rd(`REG_END_STATUS, 32'h5A, 32'hFF);
		rd(`REG_COUNT, 32'h10);
		chk("reply tag", 32'h0, 32'(link_out.srv_out));
		cu_u.stat_off();
	endtask : t_dev_end

	task automatic end_sim();
		chk("link waits timed out", 32'h0, 32'(cu_u.n_late));
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////
	// Watchdog: a few hundred cycles are expected, so this is generous
	initial begin
		repeat (30000) @(posedge aclk);
		n_errors++;
		end_sim();
	end

	// Reset for three cycles, then the scenarios in order
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_proc_end();
		t_chain();
		t_hispeed();
		t_dev_end();
		end_sim();
	end
endmodule : selector_xfer_tb
